/* ctg_logic.sv */
/*
  Trip, guard, block and alarm decision logic of a frequency-shift
  carrier protection receiver, with a classic Wishbone register slave.
  Assumes receiver slicer levels and comparator flags arrive on pins
  asynchronously; one 100 MHz clock with synchronous active-high reset.
*/
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module ctg_logic #(
  parameter int PRETRIP_CYC  = ctg_pkg::PRETRIP_CYC,
  parameter int PREGUARD_CYC = ctg_pkg::PREGUARD_CYC,
  parameter int ALARM_CYC    = ctg_pkg::ALARM_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // wishbone slave
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic            wb_we_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // receiver and relaying pins
  input  wire ctg_pkg::ctg_in_t pin_i,
  // decision outputs
  output logic                 trip_o,
  output logic                 guard_o,
  output logic                 low_sig_o,
  output logic                 alarm_ok_o,
  output logic                 fast_block_o,
  output logic                 block_init_o,
  output logic                 valid_trip_o
);
  import ctg_pkg::*;

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  ctg_in_t in_s;
  logic [IN_W-1:0] in_vec;

  // comparator and relay levels come from another world
  ctg_sync #(
    .W (IN_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_i),
    .q_o   (in_vec)
  );

  assign in_s = ctg_in_t'(in_vec);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [2:0] ctrl_q;
  logic       noise_en;
  logic       trip_boost;
  logic       blk_sel;

  assign noise_en   = ctrl_q[CTRL_NOISE_EN];
  assign trip_boost = ctrl_q[CTRL_TRIP_BOOST];
  assign blk_sel    = ctrl_q[CTRL_BLK_SEL];

  // ----------------------------------------
  // block sources
  // ----------------------------------------
  logic int_blk;
  logic blk_line;
  logic ext_any;
  logic lvl_abn;
  logic abn;

  // a rise is noise only outside trip-boost systems
  assign int_blk  = noise_en & (in_s.env_drop | (in_s.env_rise & ~trip_boost));
  assign blk_line = blk_sel ? in_s.ext_dig : int_blk;
  assign ext_any  = ~blk_sel & (|in_s.ext_blk);
  assign lvl_abn  = in_s.lvl_hi | in_s.lvl_lo;
  // level checks only enter abn while the internal source is selected
  assign abn      = blk_line | ext_any | (~blk_sel & lvl_abn);

  // ----------------------------------------
  // guard-to-trip arming
  // ----------------------------------------
  logic guard_prev_q;
  logic armed_q;
  logic armed_d;

  // trip counts only after guard has been seen to fall
  assign armed_d = in_s.guard ? 1'b0 : (guard_prev_q | armed_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_prev_q <= 1'b0;
      armed_q      <= 1'b0;
    end else begin
      guard_prev_q <= in_s.guard;
      armed_q      <= armed_d;
    end
  end

  // ----------------------------------------
  // pretrip and preguard timers
  // ----------------------------------------
  logic trip_run;
  logic trip_done;
  logic guard_run;
  logic guard_done;
  logic valid_trip;
  logic valid_guard;

  // receiver keeps trip low in guard, so arming is meaningful
  assign trip_run  = in_s.trip & armed_d & ~abn;
  // guard input is blocked only by a low level
  assign guard_run = in_s.guard & ~in_s.lvl_lo;

  ctg_timer #(
    .LIM (PRETRIP_CYC)
  ) u_pretrip (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (trip_run),
    .done_o (trip_done)
  );

  ctg_timer #(
    .LIM (PREGUARD_CYC)
  ) u_preguard (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (guard_run),
    .done_o (guard_done)
  );

  assign valid_trip  = trip_done;
  assign valid_guard = guard_done;

  // ----------------------------------------
  // alarm persistence and recovery
  // ----------------------------------------
  logic alarm_q;
  logic alm_run;
  logic alm_done;
  logic nrm_run;
  logic nrm_done;

  assign alm_run = abn;
  // recovery needs in-limit, noise-free guard
  assign nrm_run = alarm_q & ~lvl_abn & ~blk_line & in_s.guard;

  ctg_timer #(
    .LIM (ALARM_CYC)
  ) u_alarm (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (alm_run),
    .done_o (alm_done)
  );

  ctg_timer #(
    .LIM (ALARM_CYC)
  ) u_normal (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (nrm_run),
    .done_o (nrm_done)
  );

  // a fresh persistence wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else if (alm_done) begin
      alarm_q <= 1'b1;
    end else if (in_s.clr | nrm_done) begin
      alarm_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // output decisions
  // ----------------------------------------
  logic trip_d;
  logic guard_d;

  // stop-trip dominates, then direct trip, then a valid trip
  assign trip_d  = ~in_s.stop & (in_s.direct | valid_trip);
  // alarm blocks guard; trip and guard are exclusive
  assign guard_d = valid_guard & ~alarm_q & ~trip_d;

  // every output leaves through a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o       <= 1'b0;
      guard_o      <= 1'b0;
      low_sig_o    <= 1'b0;
      alarm_ok_o   <= 1'b0;
      fast_block_o <= 1'b0;
      block_init_o <= 1'b0;
      valid_trip_o <= 1'b0;
    end else begin
      trip_o       <= trip_d;
      guard_o      <= guard_d;
      low_sig_o    <= in_s.lvl_lo;
      alarm_ok_o   <= ~alarm_q;
      fast_block_o <= abn;
      block_init_o <= int_blk;
      valid_trip_o <= valid_trip;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic        req;
  logic        wr_ctrl;
  logic [31:0] rd_data;
  logic [7:0]  status;

  assign req     = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr_ctrl = req & wb_we_i & wb_ack_o & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
  assign status  = {guard_o, trip_o, low_sig_o, block_init_o,
                    fast_block_o, alarm_q, valid_guard, valid_trip};

  // unmapped reads return zero, writes there are dropped
  assign rd_data = (wb_adr_i == ADR_CTRL)   ? {29'h0, ctrl_q} :
                   (wb_adr_i == ADR_STATUS) ? {24'h0, status} :
                   (wb_adr_i == ADR_INPUT)  ? {18'h0, in_vec} : 32'h0;

  // single-wait-state answer; ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop;
    in_s.stop;
  endsequence

  sequence s_direct;
    !in_s.stop && in_s.direct;
  endsequence

  property p_stop_blocks;
    s_stop |=> !trip_o;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks)
    else $error("trip output active under stop-trip");

  property p_direct_trips;
    s_direct |=> trip_o;
  endproperty
  a_direct_trips: assert property (p_direct_trips)
    else $error("direct trip did not assert trip output");

  property p_ext_block;
    !blk_sel && (|in_s.ext_blk) && !in_s.direct |=> !trip_o && fast_block_o;
  endproperty
  a_ext_block: assert property (p_ext_block)
    else $error("external block failed to suppress trip");

  property p_trip_cause;
    $rose(trip_o) |-> $past(in_s.direct) || $past(valid_trip);
  endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip output without valid trip or direct");

  property p_exclusive;
    !(trip_o && guard_o);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("trip and guard outputs both active");

  property p_low_sig;
    in_s.lvl_lo |=> low_sig_o ##1 (low_sig_o || !$past(in_s.lvl_lo));
  endproperty
  a_low_sig: assert property (p_low_sig)
    else $error("low-signal output missed low level");

  property p_level_abn;
    !blk_sel && (in_s.lvl_hi || in_s.lvl_lo) && !in_s.direct |=> fast_block_o && !trip_o;
  endproperty
  a_level_abn: assert property (p_level_abn)
    else $error("out-of-limit level not blocking");

  property p_noise;
    noise_en && in_s.env_drop |=> block_init_o;
  endproperty
  a_noise: assert property (p_noise)
    else $error("envelope drop not flagged as noise");

  property p_boost_rise;
    trip_boost && !in_s.env_drop |=> !block_init_o;
  endproperty
  a_boost_rise: assert property (p_boost_rise)
    else $error("rise counted as noise in trip-boost");

  property p_alarm_entry;
    $rose(alarm_q) |-> $past(alm_done) && $past(abn);
  endproperty
  a_alarm_entry: assert property (p_alarm_entry)
    else $error("alarm entered without persistence");

  property p_alarm_out;
    alarm_q |=> !alarm_ok_o;
  endproperty
  a_alarm_out: assert property (p_alarm_out)
    else $error("alarm output not dropped in alarm");

  property p_clear;
    alarm_q && in_s.clr && !alm_done |=> !alarm_q ##1 alarm_ok_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("alarm-clear did not end alarm");

  property p_valid_trip;
    valid_trip |=> valid_trip_o;
  endproperty
  a_valid_trip: assert property (p_valid_trip)
    else $error("valid-trip indicator missing");

  property p_sel_ext;
    blk_sel && in_s.ext_dig |=> fast_block_o;
  endproperty
  a_sel_ext: assert property (p_sel_ext)
    else $error("external digital block not routed");

  property p_vtrip_arm;
    valid_trip |-> armed_q && in_s.trip && !abn;
  endproperty
  a_vtrip_arm: assert property (p_vtrip_arm)
    else $error("valid trip without armed unblocked trip");

endmodule

/* ctg_pkg.sv */
/*
  Shared constants, register map and carrier types for the carrier
  trip/guard decision logic.
  Assumes a single 100 MHz system clock and a classic Wishbone host.
*/
package ctg_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_KHZ     = 100_000;
  localparam int PRETRIP_MS  = 6;
  localparam int PREGUARD_MS = 4;
  localparam int ALARM_MS    = 300;
  localparam int PRETRIP_CYC  = PRETRIP_MS * CLK_KHZ;
  localparam int PREGUARD_CYC = PREGUARD_MS * CLK_KHZ;
  localparam int ALARM_CYC    = ALARM_MS * CLK_KHZ;
  localparam int CNT_W        = 25;

  // comparator thresholds, applied by the analogue front end
  localparam int LVL_HI_MV    = 7000;
  localparam int LVL_LO_MV    = 90;
  localparam int DROP_PCT     = 11;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_INPUT  = 8'h08;

  localparam int CTRL_NOISE_EN   = 0;
  localparam int CTRL_TRIP_BOOST = 1;
  localparam int CTRL_BLK_SEL    = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;

  localparam int IN_W = 14;

  // ----------------------------------------
  // carrier for the pin inputs
  // ----------------------------------------
  typedef struct packed {
    logic       trip;
    logic       guard;
    logic       lvl_hi;
    logic       lvl_lo;
    logic       env_drop;
    logic       env_rise;
    logic [3:0] ext_blk;
    logic       ext_dig;
    logic       stop;
    logic       direct;
    logic       clr;
  } ctg_in_t;

endpackage

/* ctg_sync.sv */
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
module ctg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ----------------------------------------
  // per-bit double flop
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first flop feeds only the second
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= d_i[i];
          sync_q <= meta_q;
        end
      end
      assign q_o[i] = sync_q;
    end
  endgenerate

endmodule

/* ctg_timer.sv */
/*
  Slow-to-operate, fast-to-release qualification timer.
  Assumes run is a same-clock level; done rises after LIM cycles of run.
*/
`timescale 1ns/1ps
module ctg_timer #(
  parameter int LIM = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      done_o
);
  import ctg_pkg::*;

  localparam logic [CNT_W-1:0] LIM_C = CNT_W'(LIM);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ----------------------------------------
  // counter, restarts the moment run drops
  // ----------------------------------------
  assign cnt_d  = !run_i ? '0 : (cnt_q == LIM_C) ? cnt_q : cnt_q + 1'b1;
  assign done_o = run_i && (cnt_q == LIM_C);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* ctg_rx_model.sv */
/*
  Behavioural model of the receiver slicer and the relaying equipment
  that feed the trip/guard decision logic.
  Assumes the bench picks the channel state and the side flags each cycle.
*/
`timescale 1ns/1ps
module ctg_rx_model
  import ctg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  input  wire ctg_pkg::ctg_in_t aux_i,
  output ctg_pkg::ctg_in_t pin_o
);
  // ----------------------------------------
  // slicer outputs
  // ----------------------------------------
  ctg_in_t nxt;

  // mode 0 = neither, 1 = guard, 2 = trip; trip and guard never overlap
  always_comb begin
    nxt       = aux_i;
    nxt.trip  = (mode_i == 2'h2);
    nxt.guard = (mode_i == 2'h1);
  end

  // one write per edge, so the whole word changes together
  always_ff @(posedge clk_i) begin
    pin_o <= nxt;
  end
endmodule

/* testbench.sv */
/*
  Self-checking bench for the trip/guard decision logic.
  Assumes shortened timers (12/8/40 cycles) and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import ctg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int PT = 12;
  localparam int PG = 8;
  localparam int AL = 40;
  localparam int LT = 5;
  localparam logic [6:0] T = 7'h40, G = 7'h20, L = 7'h10, A = 7'h08;
  localparam logic [6:0] F = 7'h04, B = 7'h02, V = 7'h01;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  logic [1:0]  mode;
  ctg_in_t     aux, pin;
  logic        trip_o, guard_o, low_o, alok_o, fb_o, bi_o, vt_o;
  logic [6:0]  outs;
  int          err_total, num_checks, cycles;

  assign outs = {trip_o, guard_o, low_o, alok_o, fb_o, bi_o, vt_o};

  ctg_rx_model rx (.clk_i(clk_i), .mode_i(mode), .aux_i(aux), .pin_o(pin));

  ctg_logic #(.PRETRIP_CYC(PT), .PREGUARD_CYC(PG), .ALARM_CYC(AL)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(pin), .trip_o(trip_o), .guard_o(guard_o), .low_sig_o(low_o),
    .alarm_ok_o(alok_o), .fast_block_o(fb_o), .block_init_o(bi_o), .valid_trip_o(vt_o));

  // ----------------------------------------
  // clock, timeout and checks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ceiling well above the roughly 500 cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // wait n edges, then compare the masked decision outputs
  task automatic look(input int n, input logic [6:0] m, input logic [6:0] e);
    repeat (n) @(posedge clk_i);
    #1;
    num_checks++;
    if ((outs & m) !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, outs & m, e);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, e);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    // only the bench-wide cycle ceiling ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    err_total = 0; num_checks = 0; cycles = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; wdat = 32'h0; sel = 4'h0; mode = 2'h0; aux = '0;
    look(5, 7'h7f, 7'h00);
    @(posedge clk_i) rst_i <= 1'b0;
    look(3, A, A);
    // register map: reset value, unmapped place, missing lane
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
    chk_word(q, 32'h1);
    wb(1'b1, 8'h0c, 32'h7, 4'hf, q);
    wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
    chk_word(q, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h6, 4'he, q);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
    chk_word(q, 32'h1);
    // guard qualification, then guard-to-trip
    @(posedge clk_i) mode <= 2'h1;
    look(LT + PG - 5, G, 7'h00);
    look(8, T | G, G);
    @(posedge clk_i) mode <= 2'h0;
    look(3, T, 7'h00);
    @(posedge clk_i) mode <= 2'h2;
    look(LT + PT - 5, T | V, 7'h00);
    look(8, T | G | V, T | V);
    // stop-trip overrides valid trip and direct trip
    @(posedge clk_i) aux.stop <= 1'b1;
    look(LT, T | V, V);
    @(posedge clk_i) aux.direct <= 1'b1;
    look(LT, T, 7'h00);
    @(posedge clk_i) begin
      aux.stop <= 1'b0; aux.direct <= 1'b0; mode <= 2'h1;
    end
    look(LT + PG + 4, T | G, G);
    @(posedge clk_i) aux.direct <= 1'b1;
    look(LT, T | G, T);
    @(posedge clk_i) aux.direct <= 1'b0;
    // each external block input suppresses a trip
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) mode <= 2'h1;
      look(LT, T | V, 7'h00);
      @(posedge clk_i) mode <= 2'h0;
      @(posedge clk_i) begin
        aux.ext_blk <= 4'h1 << i; mode <= 2'h2;
      end
      look(LT, F, F);
      look(PT + 4, T | V, 7'h00);
      @(posedge clk_i) begin
        aux.ext_blk <= 4'h0; mode <= 2'h0;
      end
      look(LT, F, 7'h00);
    end
    // low level: indication, delayed alarm, recovery in guard
    @(posedge clk_i) mode <= 2'h1;
    @(posedge clk_i) aux.lvl_lo <= 1'b1;
    look(LT, L | F, L | F);
    look(AL - 10, A, A);
    look(14, A | G, 7'h00);
    @(posedge clk_i) aux.lvl_lo <= 1'b0;
    look(LT, L, 7'h00);
    look(AL - 8, A, 7'h00);
    look(14, A, A);
    // high level: alarm held without guard until cleared
    @(posedge clk_i) mode <= 2'h0;
    @(posedge clk_i) aux.lvl_hi <= 1'b1;
    look(LT, F | L, F);
    look(AL + 8, A, 7'h00);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hf, q);
    chk_word(q, 32'hc);
    @(posedge clk_i) aux.lvl_hi <= 1'b0;
    look(LT + 4, A, 7'h00);
    @(posedge clk_i) aux.clr <= 1'b1;
    look(LT, A, A);
    @(posedge clk_i) aux.clr <= 1'b0;
    // envelope noise: drop, rise, rise ignored under trip boost
    @(posedge clk_i) aux.env_drop <= 1'b1;
    look(LT, B | F, B | F);
    @(posedge clk_i) begin
      aux.env_drop <= 1'b0; aux.env_rise <= 1'b1;
    end
    look(LT, B, B);
    wb(1'b1, ADR_CTRL, 32'h3, 4'h1, q);
    look(LT, B | F, 7'h00);
    @(posedge clk_i) aux.env_rise <= 1'b0;
    // external source selected: digital block replaces internal one
    wb(1'b1, ADR_CTRL, 32'h5, 4'h1, q);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
    chk_word(q, 32'h5);
    @(posedge clk_i) aux.ext_blk <= 4'hf;
    look(LT, F, 7'h00);
    @(posedge clk_i) aux.ext_dig <= 1'b1;
    look(LT, F, F);
    @(posedge clk_i) begin
      aux.ext_dig <= 1'b0; aux.ext_blk <= 4'h0; aux.env_drop <= 1'b1;
    end
    look(LT, B | F, B);
    @(posedge clk_i) aux.env_drop <= 1'b0;
    look(LT, B, 7'h00);
    finish_test();
  end
endmodule
